// File: rtl/ifp_fetch_pc.sv
// The Avalon-MM slave port and the placing of the registers were chosen for this implementation.
`timescale 1ns/100ps
module ifp_fetch_pc (
    input  wire logic        clk,
    input  wire logic        nrst,
    // Avalon-MM slave
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    input  wire logic [3:0]  avs_byteenable,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Program memory fetch port
    output logic      [11:0] fetch_addr,
    output logic             fetch_req,
    input  wire logic [15:0] fetch_data,
    // Execute unit side
    output logic      [15:0] exec_instr,
    output logic             exec_valid,
    output logic             exec_dummy,
    input  wire logic        instr_valid,
    input  wire logic [2:0]  instr_op,
    input  wire logic        skip_taken,
    input  wire logic [11:0] target_addr,
    input  wire logic [7:0]  pcl_wdata,
    output logic      [7:0]  pcl_rdata,
    output logic      [3:0]  instruction_phase_clocks,
    output logic             cycle_end
);
    // ****************************************
    // State
    // ****************************************
    typedef struct packed {
        logic [3:0]  pch;
        logic [7:0]  program_counter_low_byte;
        logic [15:0] ir;
        logic        ir_valid;
        logic        dummy;
        logic        br_pend;
        logic [11:0] br_target;
        logic        osc_sel;
        logic        run;
        logic [7:0]  slow_div;
        logic        ack;
        logic [31:0] rdata;
        logic [15:0] retired;
    } ifp_core_s;

    ifp_core_s s_q;
    ifp_core_s s_d;

    ifp_clk_if cif ();

    ifp_phase_gen u_gen (
        .clk  (clk),
        .nrst (nrst),
        .cif  (cif)
    );

    // Controls toward phase generator
    // oscillator select
    assign cif.osc_sel  = s_q.osc_sel;
    assign cif.slow_div = s_q.slow_div;
    assign cif.run      = s_q.run;

    // 12-bit PC plus one, page wraps into high bits naturally
    function automatic logic [11:0] ifp_inc(input logic [11:0] pc);
        ifp_inc = pc + 12'h001;
    endfunction : ifp_inc

    // Bus hit detection, reused for read and write
    function automatic logic ifp_hit(input logic [3:0] a, input logic [3:0] r);
        ifp_hit = (a == r);
    endfunction : ifp_hit

    // ****************************************
    // Register bus helpers
    // ****************************************
    // Read word assembly; unmapped offsets read as zero so software can probe safely
    function automatic logic [31:0] ifp_read_mux(
        input logic [3:0]  a,
        input ifp_core_s   s,
        input logic [3:0]  ph
    );
        logic [31:0] w;
        w = 32'h00000000;
        if (ifp_hit(a, ifp_pkg::REG_PC_LOW_BYTE)) begin
            w = {24'h000000, s.program_counter_low_byte};
        end else if (ifp_hit(a, ifp_pkg::REG_PC_FULL)) begin
            w = {s.retired, 4'h0, s.pch, s.program_counter_low_byte};
        end else if (ifp_hit(a, ifp_pkg::REG_CONTROL)) begin
            w = {16'h0000, s.slow_div, 6'h00, s.run, s.osc_sel};
        end else if (ifp_hit(a, ifp_pkg::REG_STATUS)) begin
            w = {24'h000000, s.dummy, s.ir_valid, 2'h0, ph};
        end
        ifp_read_mux = w;
    endfunction : ifp_read_mux

    // Register writes; byte lanes gate fields so a narrow write leaves the rest alone
    function automatic ifp_core_s ifp_apply_write(
        input ifp_core_s   s,
        input logic [3:0]  a,
        input logic [3:0]  be,
        input logic [31:0] wd
    );
        ifp_core_s n;
        n = s;
        if (be[0]) begin
            if (ifp_hit(a, ifp_pkg::REG_PC_LOW_BYTE)) begin
                n.program_counter_low_byte   = wd[7:0];
                n.dummy = 1'b1;
            end else if (ifp_hit(a, ifp_pkg::REG_CONTROL)) begin
                n.osc_sel = wd[ifp_pkg::CTL_OSC_SEL_BIT];
                n.run     = wd[ifp_pkg::CTL_RUN_BIT];
            end
        end
        if (be[1] && ifp_hit(a, ifp_pkg::REG_CONTROL)) begin
            n.slow_div = wd[ifp_pkg::CTL_SLOW_DIV_LSB +: 8];
        end
        ifp_apply_write = n;
    endfunction : ifp_apply_write

    logic [11:0] pc;
    logic        t1_start;
    logic        exec_end;
    logic        bus_req;
    logic        bus_done;
    logic [11:0] nxt;

    assign pc       = {s_q.pch, s_q.program_counter_low_byte};
    assign bus_req  = (avs_read || avs_write) && !s_q.ack;
    // Acceptance edge: waitrequest is low, so only here may a write take effect
    assign bus_done = (avs_read || avs_write) && s_q.ack;
    // T1 begins on the tick that closes T4
    assign t1_start = cif.cycle_end;
    // execute result sampled at end of T4
    assign exec_end = cif.cycle_end && s_q.ir_valid && !s_q.dummy && instr_valid;

    // ****************************************
    // Pipeline and registers
    // ****************************************
    always_comb begin
        s_d     = s_q;
        nxt     = ifp_inc(pc);
        s_d.ack = 1'b0;

        if (t1_start) begin
            // fetched word enters IR while next fetch starts
            s_d.ir       = fetch_data;
            s_d.ir_valid = 1'b1;
            s_d.dummy    = 1'b0;
            if (exec_end) begin
                s_d.retired = s_q.retired + 16'h0001;
                unique case (ifp_pkg::ifp_op_e'(instr_op))
                    ifp_pkg::IFP_OP_JUMP, ifp_pkg::IFP_OP_CALL, ifp_pkg::IFP_OP_INTR: begin
                        nxt       = target_addr;
                        s_d.dummy = 1'b1;
                    end
                    ifp_pkg::IFP_OP_SKIP: begin
                        if (skip_taken) begin
                            s_d.dummy = 1'b1;
                        end
                    end
                    ifp_pkg::IFP_OP_PCL_WRITE: begin
                        nxt       = {s_q.pch, pcl_wdata};
                        s_d.dummy = 1'b1;
                    end
                    default: begin
                        nxt = ifp_inc(pc);
                    end
                endcase
            end
            s_d.pch = nxt[11:8];
            s_d.program_counter_low_byte = nxt[7:0];
        end

        // Avalon: one wait cycle, read word registered so it stands at acceptance
        if (bus_req) begin
            s_d.ack   = 1'b1;
            s_d.rdata = (avs_read) ? ifp_read_mux(avs_address, s_q, instruction_phase_clocks) : 32'h00000000;
        end

        // Write lands at the acceptance edge only; applied last so it beats T1
        if (bus_done && avs_write) begin
            s_d = ifp_apply_write(s_d, avs_address, avs_byteenable, avs_writedata);
        end
    end

    // Register all state
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q.pch       <= ifp_pkg::PC_RESET[11:8];
            s_q.program_counter_low_byte       <= ifp_pkg::PC_RESET[7:0];
            s_q.ir        <= 16'h0000;
            s_q.ir_valid  <= 1'b0;
            s_q.dummy     <= 1'b0;
            s_q.br_pend   <= 1'b0;
            s_q.br_target <= 12'h000;
            s_q.osc_sel   <= ifp_pkg::CTL_RESET[0];
            s_q.run       <= ifp_pkg::CTL_RESET[1];
            s_q.slow_div  <= ifp_pkg::SLOW_DIV_RESET;
            s_q.ack       <= 1'b0;
            s_q.rdata     <= 32'h00000000;
            s_q.retired   <= 16'h0000;
        end else begin
            s_q <= s_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    assign avs_waitrequest          = (avs_read || avs_write) && !s_q.ack;
    assign avs_readdata             = s_q.rdata;
    assign fetch_addr               = pc;
    assign fetch_req                = cif.instruction_phase_clocks[0];
    assign exec_instr               = s_q.ir;
    // 8-bit data path view of PC
    assign pcl_rdata                = s_q.program_counter_low_byte;
    assign exec_valid               = s_q.ir_valid && !s_q.dummy;
    assign exec_dummy               = s_q.dummy;
    assign instruction_phase_clocks = cif.instruction_phase_clocks;
    assign cycle_end                = cif.cycle_end;
endmodule : ifp_fetch_pc

// File: shared/ifp_pkg.sv
package ifp_pkg;
    // Avalon register word offsets (byte addresses)
    localparam logic [3:0]  REG_PC_LOW_BYTE  = 4'h0;
    localparam logic [3:0]  REG_PC_FULL      = 4'h4;
    localparam logic [3:0]  REG_CONTROL      = 4'h8;
    localparam logic [3:0]  REG_STATUS       = 4'hC;
    // Program counter geometry
    localparam int          PC_W             = 12;
    localparam int          PCL_W            = 8;
    localparam int          PCH_W            = 4;
    localparam logic [11:0] PC_RESET         = 12'h000;
    // Field positions
    localparam int          CTL_OSC_SEL_BIT  = 0;
    localparam int          CTL_RUN_BIT      = 1;
    localparam int          CTL_SLOW_DIV_LSB = 8;
    localparam logic [7:0]  SLOW_DIV_RESET   = 8'h03;
    localparam logic [1:0]  CTL_RESET        = 2'h2;
    // Instruction class codes presented with instr_valid
    typedef enum logic [2:0] {
        IFP_OP_PLAIN, IFP_OP_JUMP, IFP_OP_CALL, IFP_OP_SKIP, IFP_OP_PCL_WRITE, IFP_OP_INTR
    } ifp_op_e;
    // Phase of the instruction cycle
    typedef enum logic [1:0] {IFP_PH_T1, IFP_PH_T2, IFP_PH_T3, IFP_PH_T4} ifp_phase_e;
endpackage : ifp_pkg

// File: shared/ifp_clk_if.sv
`timescale 1ns/100ps
interface ifp_clk_if;
    logic       osc_sel;
    logic [7:0] slow_div;
    logic       run;
    logic       sys_tick;
    logic [3:0] instruction_phase_clocks;
    logic       cycle_end;
    modport gen  (input osc_sel, input slow_div, input run, output sys_tick,
                  output instruction_phase_clocks, output cycle_end);
    modport core (output osc_sel, output slow_div, output run, input sys_tick,
                  input instruction_phase_clocks, input cycle_end);
endinterface : ifp_clk_if

// File: rtl/ifp_phase_gen.sv
`timescale 1ns/100ps
module ifp_phase_gen (
    input  wire logic clk,
    input  wire logic nrst,
    ifp_clk_if.gen    cif
);
    typedef struct packed {
        logic [7:0]         div;
        ifp_pkg::ifp_phase_e ph;
    } ifp_gen_s;

    ifp_gen_s s_q;
    ifp_gen_s s_d;
    logic     tick;

    // With run set, fast source ticks every clock; slow source ticks once per divider wrap
    assign tick = cif.run && (cif.osc_sel == 1'b0 || s_q.div == cif.slow_div);

    // Phase stepping
    always_comb begin
        s_d = s_q;
        if (cif.run) begin
            s_d.div = (tick) ? 8'h00 : s_q.div + 8'h01;
        end
        if (tick) begin
            s_d.ph = ifp_pkg::ifp_phase_e'(s_q.ph + 2'h1);
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            s_q <= '{div: 8'h00, ph: ifp_pkg::IFP_PH_T1};
        end else begin
            s_q <= s_d;
        end
    end

    assign cif.instruction_phase_clocks = 4'h1 << s_q.ph;
    assign cif.sys_tick  = tick;
    assign cif.cycle_end = tick && s_q.ph == ifp_pkg::IFP_PH_T4;
endmodule : ifp_phase_gen

// File: bench/ifp_fetch_pc_properties.sv
`timescale 1ns/100ps
// ****
// Pipeline and bus checks
// ****
module ifp_fetch_pc_properties (
    input wire logic        clk,
    input wire logic        nrst,
    input wire logic        avs_read,
    input wire logic        avs_write,
    input wire logic        avs_waitrequest,
    input wire logic [11:0] fetch_addr,
    input wire logic        fetch_req,
    input wire logic        exec_valid,
    input wire logic        exec_dummy,
    input wire logic        instr_valid,
    input wire logic [2:0]  instr_op,
    input wire logic        skip_taken,
    input wire logic [11:0] target_addr,
    input wire logic [7:0]  pcl_wdata,
    input wire logic [3:0]  instruction_phase_clocks,
    input wire logic        cycle_end
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    // Results count only on the cycle end of a real, non-dummy instruction
    wire logic go = cycle_end && instr_valid && exec_valid;
    sequence s_req; $rose(avs_read) || $rose(avs_write); endsequence
    sequence s_redirect;
        go && instr_op inside {ifp_pkg::IFP_OP_JUMP, ifp_pkg::IFP_OP_CALL, ifp_pkg::IFP_OP_INTR};
    endsequence
    sequence s_bubble; exec_dummy && !exec_valid; endsequence
    a_phase_onehot: assert property ($onehot(instruction_phase_clocks))
        else $error("phase clocks not one hot");
    a_cycle_wrap: assert property (cycle_end |-> instruction_phase_clocks[3] ##1 instruction_phase_clocks[0])
        else $error("cycle end not T4 then T1");
    a_fetch_t1: assert property (fetch_req == instruction_phase_clocks[0])
        else $error("fetch outside first phase");
    a_pc_step: assert property (go && instr_op == ifp_pkg::IFP_OP_PLAIN |=> fetch_addr == $past(fetch_addr) + 12'h1)
        else $error("pc did not step by one");
    a_redirect_load: assert property (s_redirect |=> fetch_addr == $past(target_addr) ##0 s_bubble)
        else $error("branch target not loaded");
    a_pcl_page: assert property (go && instr_op == ifp_pkg::IFP_OP_PCL_WRITE |=>
        fetch_addr == {$past(fetch_addr[11:8]), $past(pcl_wdata)} ##0 s_bubble) else $error("low byte jump wrong");
    a_skip_bubble: assert property (go && instr_op == ifp_pkg::IFP_OP_SKIP && skip_taken |=> s_bubble)
        else $error("taken skip without dummy");
    a_bus_wait: assert property (s_req |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer late");
    a_dummy_excl: assert property (exec_dummy |-> !exec_valid)
        else $error("dummy cycle marked valid");
endmodule : ifp_fetch_pc_properties

bind ifp_fetch_pc ifp_fetch_pc_properties i_ifp_fetch_pc_properties (.clk, .nrst, .avs_read, .avs_write,
    .avs_waitrequest, .fetch_addr, .fetch_req, .exec_valid, .exec_dummy, .instr_valid, .instr_op, .skip_taken,
    .target_addr, .pcl_wdata, .instruction_phase_clocks, .cycle_end);

// File: bench/ifp_fetch_pc_tb.sv
`timescale 1ns/100ps
module ifp_fetch_pc_tb;
    logic        clk = 1'b0;
    logic        nrst = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic        avs_read = 1'b0;
    logic        avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0]  avs_byteenable = 4'hF;
    logic        instr_valid = 1'b0;
    logic [2:0]  instr_op = 3'h0;
    logic        skip_taken = 1'b0;
    logic [11:0] target_addr = 12'h0;
    logic [7:0]  pcl_wdata = 8'h0;
    logic [31:0] avs_readdata, rd;
    logic        avs_waitrequest, fetch_req, exec_valid, exec_dummy, cycle_end;
    logic [11:0] fetch_addr;
    logic [15:0] exec_instr;
    logic [7:0]  pcl_rdata;
    logic [3:0]  instruction_phase_clocks;
    int          err_count = 0;
    int          samples_checked = 0;
    // Program memory stand-in: word tagged with its own address
    wire  [15:0] fetch_data = {4'hA, fetch_addr};
    ifp_fetch_pc i_ifp_fetch_pc (.clk, .nrst, .avs_address, .avs_read, .avs_write, .avs_writedata,
        .avs_byteenable, .avs_readdata, .avs_waitrequest, .fetch_addr, .fetch_req, .fetch_data, .exec_instr,
        .exec_valid, .exec_dummy, .instr_valid, .instr_op, .skip_taken, .target_addr, .pcl_wdata, .pcl_rdata,
        .instruction_phase_clocks, .cycle_end);
    always #2.5 clk = ~clk;
    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        samples_checked++;
        if (got !== exp) begin
            err_count++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : check
    // Holds the request until waitrequest is seen low at an edge
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= ~wr;
        @(posedge clk);
        while (avs_waitrequest !== 1'b0) @(posedge clk);
        rd = avs_readdata;
        avs_write <= 1'b0;
        avs_read <= 1'b0;
    endtask : bus
    // Fast clock only: launch in T3 of a non-dummy cycle so inputs stand through the cycle end
    task automatic exec(input logic [2:0] op, input logic [11:0] t, input logic [7:0] w, input logic sk);
        @(negedge clk);
        while (instruction_phase_clocks !== 4'h4 || exec_valid !== 1'b1) @(negedge clk);
        @(posedge clk);
        instr_valid <= 1'b1;
        instr_op <= op;
        target_addr <= t;
        pcl_wdata <= w;
        skip_taken <= sk;
        @(posedge clk);
        instr_valid <= 1'b0;
        skip_taken <= 1'b0;
        @(negedge clk);
    endtask : exec
    task automatic test_flow;
        logic [11:0] pc;
        logic [2:0]  ops [3] = '{ifp_pkg::IFP_OP_JUMP, ifp_pkg::IFP_OP_CALL, ifp_pkg::IFP_OP_INTR};
        bus(1'b0, ifp_pkg::REG_CONTROL, 32'h0);
        check(rd, {16'h0, ifp_pkg::SLOW_DIV_RESET, 6'h0, ifp_pkg::CTL_RESET});
        exec(ifp_pkg::IFP_OP_PLAIN, 12'h0, 8'h0, 1'b0);
        pc = fetch_addr;
        exec(ifp_pkg::IFP_OP_PLAIN, 12'h0, 8'h0, 1'b0);
        check(fetch_addr, pc + 12'h1);
        check({exec_valid, exec_instr}, {1'b1, 4'hA, pc});
        foreach (ops[i]) begin
            exec(ops[i], 12'h3F0 + 12'(i), 8'h0, 1'b0);
            check({exec_dummy, fetch_addr}, {1'b1, 12'h3F0 + 12'(i)});
        end
        exec(ifp_pkg::IFP_OP_JUMP, 12'h5FE, 8'h0, 1'b0);
        exec(ifp_pkg::IFP_OP_PCL_WRITE, 12'h0, 8'h12, 1'b0);
        check({exec_dummy, fetch_addr}, {1'b1, 12'h512});
        exec(ifp_pkg::IFP_OP_SKIP, 12'h0, 8'h0, 1'b1);
        check({exec_dummy, exec_valid}, 2'h2);
        $display("flow test done");
    endtask : test_flow
    task automatic test_regs;
        logic [11:0] pc;
        int          n;
        bus(1'b1, ifp_pkg::REG_CONTROL, 32'h0300);
        pc = fetch_addr;
        bus(1'b1, ifp_pkg::REG_PC_LOW_BYTE, 32'hA5);
        bus(1'b0, ifp_pkg::REG_PC_LOW_BYTE, 32'h0);
        check({rd[7:0], pcl_rdata}, 16'hA5A5);
        bus(1'b0, ifp_pkg::REG_PC_FULL, 32'h0);
        check(rd[11:0], {pc[11:8], 8'hA5});
        bus(1'b0, 4'h2, 32'h0);
        check(rd, 32'h0);
        bus(1'b1, ifp_pkg::REG_CONTROL, 32'h0303);
        n = 0;
        @(negedge clk);
        while (cycle_end !== 1'b1) @(negedge clk);
        do begin
            @(negedge clk);
            n++;
        end while (cycle_end !== 1'b1 && n < 100);
        check(n, 16);
        bus(1'b1, ifp_pkg::REG_CONTROL, 32'h0302);
        $display("register test done");
    endtask : test_regs
    task automatic finish_test;
        $display("checks=%0d errors=%0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : finish_test
    // Watchdog well beyond the expected run of under two hundred cycles
    initial begin
        #20000;
        err_count++;
        finish_test();
    end
    initial begin
        repeat (10) @(posedge clk);
        check(fetch_addr, 32'h0);
        nrst <= 1'b1;
        test_flow();
        test_regs();
        finish_test();
    end
endmodule : ifp_fetch_pc_tb
